//--- src/sapr_pkg.sv
// shared constants and types for the converter readout logic
package sapr_pkg;
   localparam int SAPR_RES_W = 14;
   localparam int SAPR_BYTE_W = 8;
   localparam int SAPR_LOW_W = 6;
   localparam logic [13:0] SAPR_CODE_FULL = 14'h3FFF;
   localparam logic [13:0] SAPR_CODE_MID = 14'h2000;
   localparam logic [13:0] SAPR_CODE_ZERO = 14'h0000;
   localparam logic [13:0] SAPR_CODE_RESET = 14'h3F80;
   localparam int SAPR_LSB_DIV = 16384;
   localparam int SAPR_CLK_MHZ = 100;
   localparam int SAPR_CONV_NS = 273;
   localparam int SAPR_ABORT_NS = 45;
   // longest times round down
   localparam int SAPR_CONV_CYC = (SAPR_CONV_NS * SAPR_CLK_MHZ) / 1000;
   localparam int SAPR_ABORT_CYC = (SAPR_ABORT_NS * SAPR_CLK_MHZ) / 1000;
   localparam int SAPR_PWD_NS = 10000;
   localparam int SAPR_WAKE_NS = 1000;
   localparam int SAPR_PWD_CYC = (SAPR_PWD_NS * SAPR_CLK_MHZ) / 1000;
   localparam int SAPR_WAKE_CYC = (SAPR_WAKE_NS * SAPR_CLK_MHZ) / 1000;
   localparam int SAPR_INVALID_CNT = 4;
   localparam int SAPR_FIFO_DEPTH = 8;
   localparam int SAPR_CNT_W = 20;

   typedef enum logic [2:0] {
      SAPR_IDLE = 3'b000,
      SAPR_CONV = 3'b001,
      SAPR_RST = 3'b010,
      SAPR_PWD = 3'b011,
      SAPR_WAKE = 3'b100,
      SAPR_NAP = 3'b101
   } sapr_state_e;

   typedef struct packed {
      logic valid;
      logic [13:0] code;
   } sapr_result_s;
endpackage

//--- src/sapr_fifo.sv
// small fifo holding finished conversion results
`timescale 1ns/100ps
module sapr_fifo #(
   parameter int WIDTH = 15,
   parameter int DEPTH = 8
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;
   logic [WIDTH-1:0] out_data_r;
   logic out_valid_r;

   // ready counts stored words only; the output register holds one word more so a shown word stays put
   assign in_ready = (count_r != DEPTH[AW:0]);
   assign push = in_valid && in_ready && clk_en;
   assign pop = clk_en && (count_r != '0) && (!out_valid_r || out_ready);
   assign out_valid = out_valid_r;
   assign out_data = out_data_r;

   // storage writes
   always_ff @(posedge core_clk)
   begin
      if (push)
      begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   // pointers and registered read port
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
         out_valid_r <= 1'b0;
         out_data_r <= '0;
      end
      else if (clk_en)
      begin
         if (push)
            wr_ptr_r <= wr_ptr_r + 1'b1;
         if (pop)
         begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
            out_data_r <= mem_r[rd_ptr_r];
            out_valid_r <= 1'b1;
         end
         else if (out_ready)
            out_valid_r <= 1'b0;
         count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule

//--- src/sapr_readout.sv
// digital side of a 14-bit successive-approximation converter: control and readout
// What this block does
// R1: results are straight binary, 3FFF full scale, 2000 midscale, 0000 zero.
// R2: one code step is the reference divided by 16384.
// R3: data lines driven only while chip select and read are both low.
// R4: any other chip select and read combination floats the data lines.
// R5: host avoids reads and bus turnarounds near the convert-start falling edge.
// R6: byte select low puts the full 14-bit result out, MSB on top.
// R7: byte-wide host reads top eight lines twice, byte select low then high.
// R8: byte select high gives low six bits, two zeros, lower lines zero.
// R9: byte reads work with read toggling or held low.
// R10: reset input low aborts a running conversion within 45 ns.
// R11: while in reset the output code is 3F80.
// R12: release from short reset resumes normal operation at once.
// R13: first four conversions after reset are flagged invalid.
// R14: reset held beyond the threshold time enters powerdown.
// R15: release from powerdown returns to normal within the wake delay.
// R16: conversions are timed internally and finish within 273 ns unless the result fifo is full.
// R17: host should reset after power-on once supply reaches 95 percent.
// R18: conversion starts on convert-start fall with select low, or vice versa.
// R19: busy rises at conversion start and falls when conversion ends.
// R20: select falling while busy and convert-start high aborts, giving 3F80.
// R21: with nap request low, nap is entered when busy falls until sampling.
`timescale 1ns/100ps
module sapr_readout
   import sapr_pkg::*;
#(
   parameter int PWD_CYC = SAPR_PWD_CYC,
   parameter int WAKE_CYC = SAPR_WAKE_CYC,
   parameter int CONV_CYC = SAPR_CONV_CYC
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic chip_select_n,
   input wire logic read_n,
   input wire logic byte_select,
   input wire logic convert_start_n,
   input wire logic reset_powerdown_n,
   input wire logic nap_request_n,
   input wire logic [13:0] sample_code,
   output logic [13:0] result_bus_o,
   output logic [13:0] result_bus_oe,
   output logic busy,
   output logic result_valid,
   output logic napping,
   output logic powered_down,
   output logic [13:0] stream_code,
   output logic stream_valid,
   output logic stream_ok,
   input wire logic stream_ready
);
   sapr_state_e state_r;
   sapr_state_e state_nxt;
   logic cs_d_r;
   logic cv_d_r;
   logic [SAPR_CNT_W-1:0] cnt_r;
   logic [2:0] inval_r;
   logic [13:0] result_r;
   logic [13:0] sample_r;
   logic valid_r;
   logic [13:0] drive_r;
   logic oe_r;
   logic cs_fall;
   logic cv_fall;
   logic start_conv;
   logic abort_conv;
   logic rst_in;
   logic conv_done;
   logic pwd_reached;
   logic wake_done;
   logic fifo_ready;
   logic push_res;
   logic [13:0] rd_word;
   logic [7:0] low_byte;
   sapr_result_s push_word;
   sapr_result_s pop_word;

   // edge detection on host strobes, inputs are synchronous to core_clk
   assign cs_fall = cs_d_r && !chip_select_n;
   assign cv_fall = cv_d_r && !convert_start_n;
   assign rst_in = !reset_powerdown_n;
   assign start_conv = (cv_fall && !chip_select_n) || (cs_fall && !convert_start_n); // R18
   assign abort_conv = cs_fall && convert_start_n && (state_r == SAPR_CONV); // R20
   // a full fifo holds off completion so no result is ever dropped
   assign conv_done = (cnt_r >= SAPR_CNT_W'(CONV_CYC - 1)) && fifo_ready; // R16
   assign pwd_reached = cnt_r >= SAPR_CNT_W'(PWD_CYC - 1); // R14
   assign wake_done = cnt_r >= SAPR_CNT_W'(WAKE_CYC - 1); // R15
   assign push_res = (state_r == SAPR_CONV) && conv_done && !rst_in && !abort_conv;

   // next state; reset pin has top priority so abort takes one edge
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         SAPR_IDLE, SAPR_NAP:
         begin
            if (rst_in)
               state_nxt = SAPR_RST; // R10
            else if (start_conv)
               state_nxt = SAPR_CONV; // R18
            else if (!nap_request_n)
               state_nxt = SAPR_NAP; // R21
            else
               state_nxt = SAPR_IDLE;
         end
         SAPR_CONV:
         begin
            if (rst_in)
               state_nxt = SAPR_RST; // R10
            else if (abort_conv || conv_done)
               state_nxt = nap_request_n ? SAPR_IDLE : SAPR_NAP; // R19 R21
         end
         SAPR_RST:
         begin
            if (!rst_in)
               state_nxt = SAPR_IDLE; // R12
            else if (pwd_reached)
               state_nxt = SAPR_PWD; // R14
         end
         SAPR_PWD:
         begin
            if (!rst_in)
               state_nxt = SAPR_WAKE;
         end
         SAPR_WAKE:
         begin
            if (rst_in)
               state_nxt = SAPR_RST;
            else if (wake_done)
               state_nxt = SAPR_IDLE; // R15
         end
         default:
            state_nxt = SAPR_IDLE;
      endcase
   end

   // state, counter and strobe history
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         state_r <= SAPR_RST;
         cnt_r <= '0;
         cs_d_r <= 1'b1;
         cv_d_r <= 1'b1;
      end
      else if (clk_en)
      begin
         state_r <= state_nxt;
         cs_d_r <= chip_select_n;
         cv_d_r <= convert_start_n;
         if (state_nxt != state_r)
            cnt_r <= '0;
         else if (!pwd_reached || state_r != SAPR_RST)
            cnt_r <= cnt_r + 1'b1;
      end
   end

   // sample captured at conversion start; result latched at end or abort
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         sample_r <= SAPR_CODE_ZERO;
         result_r <= SAPR_CODE_RESET;
         valid_r <= 1'b0;
         inval_r <= 3'h0;
      end
      else if (clk_en)
      begin
         if (start_conv && (state_r == SAPR_IDLE || state_r == SAPR_NAP) && !rst_in)
            sample_r <= sample_code; // R1 R2
         if (rst_in || state_r == SAPR_PWD || state_r == SAPR_WAKE)
         begin
            result_r <= SAPR_CODE_RESET; // R11
            valid_r <= 1'b0;
            inval_r <= 3'h0; // R13
         end
         else if (abort_conv)
         begin
            result_r <= SAPR_CODE_RESET; // R20
            valid_r <= 1'b0;
         end
         else if (push_res)
         begin
            result_r <= sample_r; // R1
            valid_r <= (inval_r == 3'(SAPR_INVALID_CNT)); // R13
            if (inval_r != 3'(SAPR_INVALID_CNT))
               inval_r <= inval_r + 3'h1;
         end
      end
   end

   // readout word: byte mode moves low six bits to the top lines
   assign low_byte = {result_r[SAPR_LOW_W-1:0], 2'b00}; // R8
   assign rd_word = byte_select ? {low_byte, {SAPR_LOW_W{1'b0}}} : result_r; // R6 R8

   // output register follows the word every cycle so held-low read works too
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         drive_r <= SAPR_CODE_RESET;
         oe_r <= 1'b0;
      end
      else if (clk_en)
      begin
         drive_r <= rd_word; // R9
         oe_r <= !chip_select_n && !read_n; // R3 R4
      end
   end

   assign result_bus_o = drive_r;
   assign result_bus_oe = {SAPR_RES_W{oe_r}}; // R3 R4
   assign busy = (state_r == SAPR_CONV); // R19
   assign result_valid = valid_r;
   assign napping = (state_r == SAPR_NAP); // R21
   assign powered_down = (state_r == SAPR_PWD); // R14

   assign push_word.valid = (inval_r == 3'(SAPR_INVALID_CNT)); // R13
   assign push_word.code = sample_r;

   // finished results also stream out through an 8-deep buffer
   sapr_fifo #(
      .WIDTH($bits(sapr_result_s)),
      .DEPTH(SAPR_FIFO_DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .reset(reset),
      .clk_en(clk_en),
      .in_valid(push_res),
      .in_ready(fifo_ready),
      .in_data(push_word),
      .out_valid(stream_valid),
      .out_ready(stream_ready),
      .out_data(pop_word)
   );

   assign stream_code = pop_word.code;
   assign stream_ok = pop_word.valid;
endmodule

//--- test/sapr_readout_chk.sv
// port assertions for the converter readout block
`timescale 1ns/100ps
module sapr_readout_chk
   import sapr_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic chip_select_n,
   input wire logic read_n,
   input wire logic byte_select,
   input wire logic convert_start_n,
   input wire logic reset_powerdown_n,
   input wire logic nap_request_n,
   input wire logic [13:0] result_bus_o,
   input wire logic [13:0] result_bus_oe,
   input wire logic busy,
   input wire logic napping,
   input wire logic powered_down
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);

   // start edge from an awake idle converter; the first edge after reset is skipped
   sequence start_seq;
      $fell(convert_start_n) && !chip_select_n && !busy && reset_powerdown_n && $past(reset_powerdown_n)
         && !powered_down && !$past(reset);
   endsequence

   a_drive_on_read: assert property (result_bus_oe[0] |-> !$past(chip_select_n) && !$past(read_n))
      else $error("bus driven without select and read");
   a_float_idle: assert property ($past(chip_select_n) || $past(read_n) |-> result_bus_oe == 14'h0000)
      else $error("bus not floated");
   a_low_byte_zero: assert property (result_bus_oe[0] && $past(byte_select) |-> result_bus_o[7:0] == 8'h00)
      else $error("low byte format wrong");
   a_reset_code: assert property (!reset_powerdown_n && !$past(reset_powerdown_n) && !$past(reset_powerdown_n, 2)
      && !powered_down && result_bus_oe[0] && !$past(byte_select) |-> result_bus_o == SAPR_CODE_RESET)
      else $error("reset code missing");
   a_reset_abort: assert property (!reset_powerdown_n |=> !busy)
      else $error("conversion not aborted by reset");
   a_busy_hold: assert property (start_seq |=> busy [*8])
      else $error("busy not held after start");
   a_abort_stops: assert property ($fell(chip_select_n) && convert_start_n && busy |=> !busy)
      else $error("abort ignored");
   a_nap_idle: assert property (napping |-> !busy)
      else $error("nap during conversion");
   a_nap_entry: assert property ($fell(busy) && !$past(nap_request_n) && $past(reset_powerdown_n) |-> napping)
      else $error("nap not entered after conversion");
endmodule

bind sapr_readout sapr_readout_chk u_chk (.core_clk, .reset, .chip_select_n, .read_n, .byte_select,
   .convert_start_n, .reset_powerdown_n, .nap_request_n, .result_bus_o, .result_bus_oe, .busy, .napping,
   .powered_down);

//--- test/sapr_host.sv
// host-side model driving the converter control pins
`timescale 1ns/100ps
module sapr_host (
   input wire logic core_clk,
   input wire logic [13:0] result_bus_o,
   input wire logic [13:0] result_bus_oe,
   output logic chip_select_n,
   output logic read_n,
   output logic byte_select,
   output logic convert_start_n,
   output logic reset_powerdown_n,
   output logic nap_request_n
);
   // released lines read as high impedance (Z), never as stale data
   wire logic [13:0] bus = result_bus_oe[0] ? result_bus_o : 14'hZZZZ;

   // idle pins; reset held from power-on until the bench lets go
   initial
   begin
      chip_select_n = 1'b1;
      read_n = 1'b1;
      byte_select = 1'b0;
      convert_start_n = 1'b1;
      reset_powerdown_n = 1'b0;
      nap_request_n = 1'b1;
   end

   // start: convert-start falls with select low, then rises to sample again
   task automatic conv();
      @(posedge core_clk);
      chip_select_n <= 1'b0;
      convert_start_n <= 1'b0;
      @(posedge core_clk);
      convert_start_n <= 1'b1;
   endtask

   // reads only long after a start edge; byte pairs may keep the strobe low
   task automatic rd(input logic b, input logic hold, output logic [13:0] d);
      @(posedge core_clk);
      chip_select_n <= 1'b0;
      read_n <= 1'b0;
      byte_select <= b;
      @(posedge core_clk);
      @(negedge core_clk);
      d = bus;
      if (!hold)
      begin
         @(posedge core_clk);
         read_n <= 1'b1;
      end
   endtask
endmodule

//--- test/test_sapr_readout.sv
// self-checking bench for the converter readout block
`timescale 1ns/100ps
module test_sapr_readout;
   import sapr_pkg::*;
   logic core_clk = 1'b0, reset = 1'b1, stream_ready = 1'b0, fill = 1'b0;
   logic [13:0] sample_code = 14'h0000, d, c;
   logic [14:0] expq[$];
   logic [13:0] codes[4] = '{14'h3FFF, 14'h2000, 14'h1FFF, 14'h0000};
   wire logic chip_select_n, read_n, byte_select, convert_start_n, reset_powerdown_n, nap_request_n;
   wire logic busy, result_valid, napping, powered_down, stream_valid, stream_ok;
   wire logic [13:0] result_bus_o, result_bus_oe, stream_code;
   int n_errors = 0, check_count = 0, cyc = 0, done_cnt = 0, n = 0, k = 0;
   sapr_readout #(.PWD_CYC(20), .WAKE_CYC(5)) u_dut (.core_clk, .reset, .clk_en(1'b1), .chip_select_n, .read_n,
      .byte_select, .convert_start_n, .reset_powerdown_n, .nap_request_n, .sample_code, .result_bus_o,
      .result_bus_oe, .busy, .result_valid, .napping, .powered_down, .stream_code, .stream_valid, .stream_ok,
      .stream_ready);
   sapr_host u_host (.core_clk, .result_bus_o, .result_bus_oe, .chip_select_n, .read_n, .byte_select,
      .convert_start_n, .reset_powerdown_n, .nap_request_n);
   // 100 MHz clock
   initial
   begin
      forever #5 core_clk = ~core_clk;
   end
   task automatic chk(input string what, input logic [14:0] seen, input logic [14:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // one conversion; the model queues the code and its validity
   task automatic run(input logic [13:0] cv);
      @(posedge core_clk);
      sample_code <= cv;
      u_host.conv();
      expq.push_back({done_cnt >= 4, cv});
      done_cnt++;
      @(negedge core_clk);
      for (n = 0; n < 60 && busy === 1'b1; n++)
         @(negedge core_clk);
      if (!fill)
         chk("busy", 15'(n), 15'(SAPR_CONV_CYC));
   endtask
   // table codes first, then random; word, byte pair and float checked each time
   task automatic batch(input int cnt);
      for (int i = 0; i < cnt; i++)
      begin
         c = (i < 4) ? codes[i] : 14'($urandom);
         run(c);
         chk("valid", 15'(result_valid), 15'(done_cnt > 4));
         u_host.rd(1'b0, 1'b0, d);
         chk("word", 15'(d), 15'(c));
         u_host.rd(1'b0, 1'b1, d);
         chk("top", 15'(d[13:6]), 15'(c[13:6]));
         u_host.rd(1'b1, 1'b0, d);
         chk("low", 15'(d), 15'({c[5:0], 8'h00}));
         repeat (2) @(negedge core_clk);
         chk("float", 15'(result_bus_oe), 15'h0000);
      end
   endtask
   task automatic drain();
      @(posedge core_clk);
      for (int i = 0; i < 600 && expq.size() > 0; i++)
         @(posedge core_clk);
      chk("drain", 15'(expq.size()), 15'h0000);
   endtask
   // random stall from the sink, held off entirely while filling
   always @(posedge core_clk)
      stream_ready <= !fill && ($urandom % 4 != 0);
   always @(posedge core_clk)
      if (!reset && stream_valid === 1'b1 && stream_ready)
         chk("stream", {stream_ok, stream_code}, expq.pop_front());
   // hang guard, well above the expected run length
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         $display("Error timeout expected end seen hang");
         give_verdict();
      end
   end
   initial
   begin
      void'($urandom(45));
      repeat (8) @(posedge core_clk);
      u_host.reset_powerdown_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      batch(6);
      $display("test words done");
      u_host.conv();
      repeat (10) @(posedge core_clk);
      u_host.chip_select_n <= 1'b1;
      @(posedge core_clk);
      u_host.chip_select_n <= 1'b0;
      repeat (2) @(negedge core_clk);
      chk("abort busy", 15'(busy), 15'h0000);
      u_host.rd(1'b0, 1'b0, d);
      chk("abort code", 15'(d), 15'(SAPR_CODE_RESET));
      drain();
      // start by select falling while convert-start is already low
      @(posedge core_clk);
      sample_code <= 14'($urandom);
      u_host.chip_select_n <= 1'b1;
      u_host.convert_start_n <= 1'b0;
      @(posedge core_clk);
      u_host.chip_select_n <= 1'b0;
      c = sample_code;
      expq.push_back({done_cnt >= 4, c});
      done_cnt++;
      @(posedge core_clk);
      u_host.convert_start_n <= 1'b1;
      repeat (2) @(negedge core_clk);
      chk("select start", 15'(busy), 15'h0001);
      repeat (30) @(negedge core_clk);
      u_host.rd(1'b0, 1'b0, d);
      chk("select word", 15'(d), 15'(c));
      u_host.conv();
      repeat (10) @(posedge core_clk);
      u_host.reset_powerdown_n <= 1'b0;
      repeat (4) @(negedge core_clk);
      chk("reset busy", 15'(busy), 15'h0000);
      u_host.rd(1'b0, 1'b0, d);
      chk("reset code", 15'(d), 15'(SAPR_CODE_RESET));
      @(posedge core_clk);
      u_host.reset_powerdown_n <= 1'b1;
      done_cnt = 0;
      batch(5);
      $display("test abort and reset done");
      drain();
      u_host.reset_powerdown_n <= 1'b0;
      repeat (23) @(negedge core_clk);
      chk("powerdown", 15'(powered_down), 15'h0001);
      @(posedge core_clk);
      u_host.reset_powerdown_n <= 1'b1;
      repeat (7) @(posedge core_clk);
      done_cnt = 0;
      run(14'($urandom));
      chk("awake", 15'(powered_down), 15'h0000);
      @(posedge core_clk);
      u_host.nap_request_n <= 1'b0;
      run(14'($urandom));
      repeat (2) @(negedge core_clk);
      chk("nap", 15'(napping), 15'h0001);
      run(14'($urandom));
      @(posedge core_clk);
      u_host.nap_request_n <= 1'b1;
      $display("test power modes done");
      drain();
      fill = 1'b1;
      while (n <= SAPR_CONV_CYC && k < 12)
      begin
         run(14'($urandom));
         k++;
      end
      chk("stall", 15'(n > SAPR_CONV_CYC), 15'h0001);
      chk("depth", 15'(k >= 9), 15'h0001);
      fill = 1'b0;
      drain();
      $display("test buffer done");
      give_verdict();
   end
endmodule
